//--- rtl/ipc_regs.svh
// Register offsets, field positions, reset values and sizes of the interrupt priority controller.
// =====================================================================
// What this block does
// RULE1 - Test register bits 11-8 show the new CPU priority level, 0 to 15.
// RULE2 - Bits 6-0 show the vector number, with capture clear: last acknowledged interrupt.
// RULE3 - With capture set, the vector field tracks the highest priority pending interrupt.
// RULE4 - Bit 15 flags a request held off because CPU priority is equal or higher.
// RULE5 - Every device reset sets each user source priority to level 4.
// RULE6 - Priority zero disables a source; 1 to 7 are levels, 7 highest.
// RULE7 - Nesting disable stops user interrupts preempting a routine in progress.
// RULE8 - Only enabled sources interrupt; flags record events regardless of enable.
// RULE9 - Flags stay set until software clears them; a set flag re-interrupts after return.
// RULE10 - Return pops saved program counter, status low byte and old CPU level.
// RULE11 - Traps set flags in control register one; uncleared flags re-enter the trap.
// RULE12 - CPU priority 7 in the status word blocks all user interrupts.
// RULE13 - Traps use levels 8 to 15 and are never masked; the code holds a trap off unless its level is above the CPU level.
// RULE14 - Timed mask blocks user levels 1 to 6 for a programmed period.
// RULE15 - Level 7 user interrupts pass while the timed mask runs.
// RULE16 - Highest enabled level wins, ties by index, only if above CPU level.
`ifndef IPC_REGS_SVH
`define IPC_REGS_SVH

// =====================================================================
// Register byte offsets on the register bus.
`define IPC_OFF_CTRL1      8'h00
`define IPC_OFF_FLAGS      8'h04
`define IPC_OFF_ENABLE     8'h08
`define IPC_OFF_PRIO       8'h0C
`define IPC_OFF_STATUS     8'h10
`define IPC_OFF_TEST       8'h14
`define IPC_OFF_TMASK      8'h18

// =====================================================================
// Field positions.
`define IPC_CTRL1_NEST_BIT 15
`define IPC_TEST_REQ_BIT   15
`define IPC_TEST_CAP_BIT   13
`define IPC_TEST_LVL_LSB   8
`define IPC_SR_IPL3_BIT    4

// =====================================================================
// Sizes, levels and reset values.
`define IPC_NSRC           8
`define IPC_NTRAP          8
`define IPC_STACK_DEPTH    16
`define IPC_PRIO_RST       24'h924924
`define IPC_USER_VEC_BASE  7'h08
`define IPC_TRAP_LVL_BASE  4'h8
`define IPC_TIMED_PASS_LVL 4'h7
`define IPC_RESP_OKAY      2'h0
`define IPC_RESP_SLVERR    2'h2

`endif

//--- rtl/ipc_pkg.sv
// Types shared by the interrupt priority controller and its users.
`include "ipc_regs.svh"

package ipc_pkg;

    // =====================================================================
    // Request towards the CPU core.
    typedef struct packed {
        logic       irq;
        logic [3:0] level;
        logic [6:0] vector;
    } ipc_cpu_req_s;

    // Context handed back on return from interrupt.
    typedef struct packed {
        logic        valid;
        logic [15:0] pc;
    } ipc_ret_s;

    // Whole state of the controller.
    typedef struct packed {
        logic                         awready;
        logic                         wready;
        logic                         bvalid;
        logic [1:0]                   bresp;
        logic                         aw_got;
        logic                         w_got;
        logic [7:0]                   awaddr;
        logic [31:0]                  wdata;
        logic [3:0]                   wstrb;
        logic                         arready;
        logic                         rvalid;
        logic [1:0]                   rresp;
        logic [31:0]                  rdata;
        logic                         nest_dis;
        logic [7:0]                   trap_flag;
        logic [7:0]                   src_flag;
        logic [7:0]                   src_en;
        logic [23:0]                  src_prio;
        logic [7:0]                   status_low;
        logic                         capture;
        logic [15:0]                  mask_cnt;
        logic [6:0]                   acked_vec;
        logic [3:0]                   new_level;
        logic                         req_pend;
        logic [6:0]                   vec_view;
        ipc_cpu_req_s                 req;
        ipc_ret_s                     ret;
        logic [4:0]                   depth;
        logic [15:0][23:0]            stack;
    } ipc_state_s;

endpackage

//--- rtl/ipc_top.sv
// Interrupt priority controller with an AXI4-Lite register slave and a CPU request port.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`include "ipc_regs.svh"

module ipc_top
    import ipc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [7:0]   s_axil_awaddr,
    input  wire logic         s_axil_awvalid,
    output logic              s_axil_awready,
    input  wire logic [31:0]  s_axil_wdata,
    input  wire logic [3:0]   s_axil_wstrb,
    input  wire logic         s_axil_wvalid,
    output logic              s_axil_wready,
    output logic [1:0]        s_axil_bresp,
    output logic              s_axil_bvalid,
    input  wire logic         s_axil_bready,
    input  wire logic [7:0]   s_axil_araddr,
    input  wire logic         s_axil_arvalid,
    output logic              s_axil_arready,
    output logic [31:0]       s_axil_rdata,
    output logic [1:0]        s_axil_rresp,
    output logic              s_axil_rvalid,
    input  wire logic         s_axil_rready,
    input  wire logic [7:0]   src_event,
    input  wire logic [7:0]   trap_event,
    input  wire logic [15:0]  cpu_pc,
    input  wire logic         cpu_ack,
    input  wire logic         cpu_ret,
    output ipc_cpu_req_s      cpu_req,
    output ipc_ret_s          cpu_return
);

    // =====================================================================
    // Helpers.

    // Priority of user source idx, three bits per source.
    function automatic logic [3:0] user_level(input logic [23:0] prio, input int idx);
        logic [2:0] f;
        f = prio[idx*3 +: 3];
        return {1'b0, f};
    endfunction

    // CPU priority held in the status low byte.
    function automatic logic [3:0] cpu_level(input logic [7:0] sr);
        return {sr[`IPC_SR_IPL3_BIT], sr[3:1]};
    endfunction

    // Merge write data into a register under the byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    ipc_state_s  s;
    ipc_state_s  next_s;
    logic [3:0]  cur_level;
    logic [3:0]  lvl;
    logic [3:0]  best_lvl;
    logic [6:0]  best_vec;
    logic        best_trap;
    logic        cand_any;
    logic        best_ok;
    logic        do_write;
    logic        wr_flags;
    logic [31:0] wval;
    logic [31:0] rval;
    logic        rhit;
    logic [23:0] top;

    // =====================================================================
    // Arbitration: pick the highest level among eligible requests.
    // Lower index wins ties because replacement needs a strictly higher level.
    always_comb begin
        cur_level = cpu_level(s.status_low);
        best_lvl  = 4'h0;
        best_vec  = 7'h00;
        best_trap = 1'b0;
        cand_any  = 1'b0;
        lvl       = 4'h0;
        for (int i = 0; i < `IPC_NSRC; i++) begin
            lvl = user_level(s.src_prio, i);
            if (s.src_flag[i] && s.src_en[i] && lvl != 4'h0                             // [RULE8] [RULE6]
                && !(s.mask_cnt != 16'h0000 && lvl < `IPC_TIMED_PASS_LVL)              // [RULE14] [RULE15]
                && !(s.nest_dis && s.depth != 5'h00)) begin                            // [RULE7]
                if (!cand_any || lvl > best_lvl) begin                                 // [RULE16]
                    best_lvl = lvl;
                    best_vec = `IPC_USER_VEC_BASE + 7'(i);
                end
                cand_any = 1'b1;
            end
        end
        // Traps sit above every user level; only the CPU level compare below can hold them off.
        for (int i = 0; i < `IPC_NTRAP; i++) begin
            if (s.trap_flag[i]) begin                                                  // [RULE13]
                best_lvl  = `IPC_TRAP_LVL_BASE + 4'(i);
                best_vec  = 7'(i);
                best_trap = 1'b1;
                cand_any  = 1'b1;
            end
        end
        best_ok = cand_any && best_lvl > cur_level;                                    // [RULE16] [RULE12]
    end

    // =====================================================================
    // Register read decode; unmapped words answer with a slave error.
    always_comb begin
        rhit = 1'b1;
        rval = 32'h0000_0000;
        case (s_axil_araddr)
            `IPC_OFF_CTRL1: begin
                rval[`IPC_CTRL1_NEST_BIT] = s.nest_dis;
                rval[7:0]                 = s.trap_flag;
            end
            `IPC_OFF_FLAGS:  rval[7:0]  = s.src_flag;
            `IPC_OFF_ENABLE: rval[7:0]  = s.src_en;
            `IPC_OFF_PRIO:   rval[23:0] = s.src_prio;
            `IPC_OFF_STATUS: rval[7:0]  = s.status_low;
            `IPC_OFF_TEST: begin
                rval[`IPC_TEST_REQ_BIT]                = s.req_pend;       // [RULE4]
                rval[`IPC_TEST_CAP_BIT]                = s.capture;
                rval[`IPC_TEST_LVL_LSB +: 4]           = s.new_level;      // [RULE1]
                rval[6:0]                              = s.vec_view;       // [RULE2]
            end
            `IPC_OFF_TMASK:  rval[15:0] = s.mask_cnt;
            default:         rhit = 1'b0;
        endcase
    end

    // =====================================================================
    // Next state: bus slave, flags, priorities, CPU handshake and context stack.
    always_comb begin
        next_s         = s;
        next_s.ret.valid = 1'b0;
        do_write       = s.aw_got && s.w_got && !s.bvalid;
        wr_flags       = do_write && s.awaddr == `IPC_OFF_FLAGS;
        top            = 24'h000000;
        wval           = 32'h0000_0000;

        // Write address and data are taken independently, in either order.
        if (s_axil_awvalid && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = s_axil_awaddr;
        end
        if (s_axil_wvalid && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axil_wdata;
            next_s.wstrb = s_axil_wstrb;
        end
        if (s.bvalid && s_axil_bready) begin
            next_s.bvalid = 1'b0;
        end

        // Timed mask counts down to zero, one per clock.
        if (s.mask_cnt != 16'h0000) begin
            next_s.mask_cnt = s.mask_cnt - 16'h0001;                           // [RULE14]
        end

        // Software writes; flag bits clear by writing one.
        if (do_write) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = `IPC_RESP_OKAY;
            case (s.awaddr)
                `IPC_OFF_CTRL1: begin
                    wval = merge({16'h0000, s.nest_dis, 7'h00, s.trap_flag}, s.wdata, s.wstrb);
                    next_s.nest_dis  = wval[`IPC_CTRL1_NEST_BIT];              // [RULE7]
                    next_s.trap_flag = s.trap_flag & ~wval[7:0];               // [RULE11]
                end
                `IPC_OFF_FLAGS: begin
                    wval = merge(32'h0000_0000, s.wdata, s.wstrb);
                    next_s.src_flag = s.src_flag & ~wval[7:0];                 // [RULE9]
                end
                `IPC_OFF_ENABLE: begin
                    wval = merge({24'h000000, s.src_en}, s.wdata, s.wstrb);
                    next_s.src_en = wval[7:0];
                end
                `IPC_OFF_PRIO: begin
                    wval = merge({8'h00, s.src_prio}, s.wdata, s.wstrb);
                    next_s.src_prio = wval[23:0];
                end
                `IPC_OFF_STATUS: begin
                    wval = merge({24'h000000, s.status_low}, s.wdata, s.wstrb);
                    next_s.status_low = wval[7:0];                             // [RULE12]
                end
                `IPC_OFF_TEST: begin
                    wval = merge({18'h00000, s.capture, 13'h0000}, s.wdata, s.wstrb);
                    next_s.capture = wval[`IPC_TEST_CAP_BIT];
                end
                `IPC_OFF_TMASK: begin
                    wval = merge({16'h0000, s.mask_cnt}, s.wdata, s.wstrb);
                    next_s.mask_cnt = wval[15:0];                              // [RULE14]
                end
                default: next_s.bresp = `IPC_RESP_SLVERR;
            endcase
        end

        // Events set flags after the clear so that a coincident event is kept.
        next_s.src_flag  = next_s.src_flag | src_event;                        // [RULE8] [RULE9]
        next_s.trap_flag = next_s.trap_flag | trap_event;                      // [RULE11]

        // Read channel answers one cycle after the address is taken.
        if (s_axil_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rval;
            next_s.rresp  = rhit ? `IPC_RESP_OKAY : `IPC_RESP_SLVERR;
        end else if (s.rvalid && s_axil_rready) begin
            next_s.rvalid = 1'b0;
        end

        // Request presented to the CPU, registered one cycle after arbitration.
        next_s.req.irq    = best_ok;                                           // [RULE16]
        next_s.req.level  = best_lvl;
        next_s.req.vector = best_vec;
        next_s.req_pend   = cand_any && best_lvl <= cur_level;                 // [RULE4]
        next_s.vec_view   = s.capture ? (cand_any ? best_vec : s.vec_view)     // [RULE3]
                                      : s.acked_vec;                           // [RULE2]

        // Return pops context; the flag left set re-requests at once.
        if (cpu_ret && s.depth != 5'h00) begin
            top                = s.stack[4'(s.depth - 5'h01)];
            next_s.depth       = s.depth - 5'h01;
            next_s.status_low  = top[7:0];                                     // [RULE10]
            next_s.ret.pc      = top[23:8];
            next_s.ret.valid   = 1'b1;
            next_s.req.irq     = 1'b0;
        end else if (cpu_ack && s.req.irq && s.depth != 5'(`IPC_STACK_DEPTH)) begin
            // Acknowledge saves context and raises the CPU level.
            next_s.stack[4'(s.depth)] = {cpu_pc, next_s.status_low};
            next_s.depth       = s.depth + 5'h01;
            next_s.acked_vec   = s.req.vector;                                 // [RULE2]
            next_s.new_level   = s.req.level;                                  // [RULE1]
            next_s.status_low[`IPC_SR_IPL3_BIT] = s.req.level[3];
            next_s.status_low[3:1] = s.req.level[2:0];
            next_s.req.irq     = 1'b0;
        end

        // Ready flags stall a second item until the write completes.
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready  = !next_s.w_got && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    // =====================================================================
    // State register with synchronous reset.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s          <= '0;
            s.src_prio <= `IPC_PRIO_RST;                                       // [RULE5]
        end else begin
            s <= next_s;
        end
    end

    // =====================================================================
    // Outputs come straight from the state register.
    assign s_axil_awready = s.awready;
    assign s_axil_wready  = s.wready;
    assign s_axil_bvalid  = s.bvalid;
    assign s_axil_bresp   = s.bresp;
    assign s_axil_arready = s.arready;
    assign s_axil_rvalid  = s.rvalid;
    assign s_axil_rdata   = s.rdata;
    assign s_axil_rresp   = s.rresp;
    assign cpu_req        = s.req;
    assign cpu_return     = s.ret;

    // =====================================================================
    // Checks on the controller's own behaviour.
    a_irq_follows_win: assert property (@(posedge clk) disable iff (sys_rst) // [RULE16]
        best_ok && !cpu_ack && !cpu_ret |=> cpu_req.irq && cpu_req.level == $past(best_lvl))
        else $error("winning request not presented");

    a_level_above_cpu: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
        cpu_req.irq && $stable(s.status_low) |-> cpu_req.level > cpu_level(s.status_low))
        else $error("request at or below cpu level");

    a_trap_unmasked: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
        (|s.trap_flag) && cpu_level(s.status_low) < `IPC_TRAP_LVL_BASE |-> best_ok && best_trap)
        else $error("trap was masked");

    a_prio_reset_four: assert property (@(posedge clk) // [RULE5]
        $past(sys_rst) && !sys_rst |-> s.src_prio == `IPC_PRIO_RST && s.depth == 5'h00)
        else $error("priorities not level four after reset");

    a_zero_prio_off: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
        cand_any && !best_trap |-> best_lvl != 4'h0)
        else $error("disabled source selected");

    a_timed_mask_pass: assert property (@(posedge clk) disable iff (sys_rst) // [RULE14]
        s.mask_cnt != 16'h0000 && cand_any && !best_trap |-> best_lvl == `IPC_TIMED_PASS_LVL)
        else $error("timed mask let low level through");

    a_nest_blocked: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
        s.nest_dis && s.depth != 5'h00 && cand_any |-> best_trap)
        else $error("user preempted with nesting disabled");

    a_ack_level: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
        cpu_ack && cpu_req.irq && !cpu_ret && s.depth != 5'(`IPC_STACK_DEPTH)
        |=> s.new_level == $past(cpu_req.level) && cpu_level(s.status_low) == s.new_level
            && !cpu_req.irq)
        else $error("acknowledge did not raise level");

    a_ret_restore: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
        cpu_ret && s.depth != 5'h00 |=> cpu_return.valid && s.depth == $past(s.depth) - 5'h01)
        else $error("return did not pop context");

    a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
        !wr_flags |=> (s.src_flag & $past(s.src_flag)) == $past(s.src_flag))
        else $error("flag dropped without software clear");

    a_req_held_off: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
        cand_any && !best_ok |=> s.req_pend ##1 1'b1)
        else $error("held off request not reported");

    a_vec_capture: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
        s.capture && cand_any |=> s.vec_view == $past(best_vec))
        else $error("vector view not tracking pending");

    // A trap event is kept even when software clears the same flag in that cycle.
    a_trap_flag_set: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
        (|trap_event) |=> (s.trap_flag & $past(trap_event)) == $past(trap_event))
        else $error("trap event lost");

    // The timed mask loses exactly one count per clock unless software reloads it.
    a_mask_counts: assert property (@(posedge clk) disable iff (sys_rst) // [RULE14]
        s.mask_cnt != 16'h0000 && !(do_write && s.awaddr == `IPC_OFF_TMASK)
        |=> s.mask_cnt == $past(s.mask_cnt) - 16'h0001)
        else $error("timed mask count skipped");

    // A pending write answer refuses further address and data items.
    a_write_refused: assert property (@(posedge clk) disable iff (sys_rst)
        s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
        else $error("write item accepted while answer pending");

endmodule

//--- tb/ipc_cpu_model.sv
// Behavioural CPU core that acknowledges interrupt requests and returns from them.
module ipc_cpu_model
    import ipc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         ack_en,
    input  wire logic         ret_go,
    input  wire ipc_cpu_req_s cpu_req,
    input  wire ipc_ret_s     cpu_return,
    output logic              cpu_ack,
    output logic              cpu_ret,
    output logic [15:0]       cpu_pc,
    output logic [6:0]        last_vec,
    output logic [15:0]       ret_pc
);
    timeunit 1ns;
    timeprecision 1ns;

    // =====================================================================
    // One acknowledge per request: the guard on cpu_ack stops a stale irq being taken twice.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpu_ack  <= 1'b0;
            cpu_ret  <= 1'b0;
            cpu_pc   <= 16'h1000;
            last_vec <= 7'h00;
            ret_pc   <= 16'h0000;
        end else begin
            cpu_ack <= ack_en && cpu_req.irq && !cpu_ack;
            cpu_ret <= ret_go;
            if (ack_en && cpu_req.irq && !cpu_ack) begin
                last_vec <= cpu_req.vector;
                cpu_pc   <= cpu_pc + 16'h0100;
            end
            if (cpu_return.valid) begin
                ret_pc <= cpu_return.pc;
            end
        end
    end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the interrupt priority controller.
`include "ipc_regs.svh"

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end

module tb_top import ipc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    // =====================================================================
    // Stimulus, bus and observation signals.
    logic               clk = 1'b0, sys_rst = 1'b1;
    logic [7:0]         awaddr = 8'h00, araddr = 8'h00, src_ev = 8'h00, trap_ev = 8'h00;
    logic [31:0]        wdata = 32'h0, rdata, rdv;
    logic               awv = 1'b0, wv = 1'b0, arv = 1'b0, bready = 1'b0, rready = 1'b0;
    logic               awready, wready, bvalid, arready, rvalid, ack_en = 1'b0, ret_go = 1'b0;
    logic               cpu_ack, cpu_ret;
    logic [1:0]         bresp, rresp, rrs, brs;
    logic [15:0]        cpu_pc, ret_pc;
    logic [6:0]         last_vec;
    ipc_cpu_req_s       cpu_req;
    ipc_ret_s           cpu_return;
    int                 fail_count = 0, tests_run = 0;

    // Clock at 100 MHz.
    always #5 clk = ~clk;

    ipc_top u_ipc_top (.clk(clk), .sys_rst(sys_rst), .s_axil_awaddr(awaddr), .s_axil_awvalid(awv),
        .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hF), .s_axil_wvalid(wv),
        .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
        .s_axil_araddr(araddr), .s_axil_arvalid(arv), .s_axil_arready(arready), .s_axil_rdata(rdata),
        .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready), .src_event(src_ev),
        .trap_event(trap_ev), .cpu_pc(cpu_pc), .cpu_ack(cpu_ack), .cpu_ret(cpu_ret),
        .cpu_req(cpu_req), .cpu_return(cpu_return));

    ipc_cpu_model u_ipc_cpu_model (.clk(clk), .sys_rst(sys_rst), .ack_en(ack_en), .ret_go(ret_go),
        .cpu_req(cpu_req), .cpu_return(cpu_return), .cpu_ack(cpu_ack), .cpu_ret(cpu_ret),
        .cpu_pc(cpu_pc), .last_vec(last_vec), .ret_pc(ret_pc));

    // =====================================================================
    // Register bus master; each channel is held until its own handshake edge.
    // Handshakes are sampled at the falling edge, where they already stand for the next rising edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_hit;
        logic w_hit;
        logic b_hit;
        awaddr <= a;
        wdata  <= d;
        awv    <= 1'b1;
        wv     <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            aw_hit = awv && awready;
            w_hit  = wv && wready;
            b_hit  = bvalid;
            brs    = bresp;
            @(posedge clk);
            if (aw_hit) awv <= 1'b0;
            if (w_hit) wv <= 1'b0;
        end while (!b_hit);
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a);
        logic ar_hit;
        logic r_hit;
        araddr <= a;
        arv    <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ar_hit = arv && arready;
            r_hit  = rvalid;
            rdv    = rdata;
            rrs    = rresp;
            @(posedge clk);
            if (ar_hit) arv <= 1'b0;
        end while (!r_hit);
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic chkr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        rd(a);
        `CHK(rdv, e)
        `CHK(rrs, er)
    endtask

    // One-cycle event pulses, then time for flag and request to settle.
    task automatic ev(input logic [7:0] s, input logic [7:0] t);
        src_ev  <= s;
        trap_ev <= t;
        @(posedge clk);
        src_ev  <= 8'h00;
        trap_ev <= 8'h00;
        repeat (3) @(posedge clk);
    endtask

    // Let the core model acknowledge the standing request once.
    task automatic take();
        ack_en <= 1'b1;
        repeat (2) @(posedge clk);
        ack_en <= 1'b0;
        @(posedge clk);
    endtask

    task automatic conclude();
        if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // =====================================================================
    // Test sequence; each step leaves state that the next one builds on.
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        chkr(`IPC_OFF_PRIO, 32'h00924924, `IPC_RESP_OKAY);
        chkr(8'h1C, 32'h0, `IPC_RESP_SLVERR);
        wr(8'h1C, 32'hFFFF_FFFF);
        `CHK(brs, `IPC_RESP_SLVERR)
        ev(8'h01, 8'h00);
        `CHK(cpu_req.irq, 1'b0)
        chkr(`IPC_OFF_FLAGS, 32'h1, `IPC_RESP_OKAY);
        wr(`IPC_OFF_PRIO, 32'h00924920);
        `CHK(brs, `IPC_RESP_OKAY)
        wr(`IPC_OFF_ENABLE, 32'h1);
        repeat (3) @(posedge clk);
        `CHK(cpu_req.irq, 1'b0)
        wr(`IPC_OFF_PRIO, 32'h00924925);
        repeat (3) @(posedge clk);
        `CHK(cpu_req, 12'hA88)
        take();
        `CHK(last_vec, 7'h08)
        chkr(`IPC_OFF_TEST, 32'h8508, `IPC_RESP_OKAY);
        // The flag is left set on purpose so the return must re-enter.
        ret_go <= 1'b1;
        @(posedge clk);
        ret_go <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(ret_pc, 16'h1100)
        `CHK(cpu_req, 12'hA88)
        chkr(`IPC_OFF_STATUS, 32'h0, `IPC_RESP_OKAY);
        wr(`IPC_OFF_FLAGS, 32'h1);
        `CHK(cpu_req.irq, 1'b0)
        wr(`IPC_OFF_STATUS, 32'h0E);
        wr(`IPC_OFF_PRIO, 32'h00924927);
        ev(8'h01, 8'h00);
        `CHK(cpu_req.irq, 1'b0)
        rd(`IPC_OFF_TEST);
        `CHK(rdv[15], 1'b1)
        ev(8'h00, 8'h04);
        `CHK(cpu_req, 12'hD02)
        chkr(`IPC_OFF_CTRL1, 32'h4, `IPC_RESP_OKAY);
        wr(`IPC_OFF_CTRL1, 32'h4);
        wr(`IPC_OFF_FLAGS, 32'h1);
        wr(`IPC_OFF_STATUS, 32'h0);
        wr(`IPC_OFF_PRIO, 32'h00924937);
        wr(`IPC_OFF_ENABLE, 32'h3);
        wr(`IPC_OFF_TMASK, 32'h0000_00C8);
        ev(8'h02, 8'h00);
        `CHK(cpu_req.irq, 1'b0)
        ev(8'h01, 8'h00);
        `CHK(cpu_req, 12'hB88)
        wr(`IPC_OFF_FLAGS, 32'h1);
        repeat (200) @(posedge clk);
        `CHK(cpu_req, 12'hB09)
        wr(`IPC_OFF_TEST, 32'h2000);
        rd(`IPC_OFF_TEST);
        `CHK(rdv[6:0], 7'h09)
        wr(`IPC_OFF_TEST, 32'h0);
        wr(`IPC_OFF_CTRL1, 32'h8000);
        take();
        `CHK(last_vec, 7'h09)
        ev(8'h01, 8'h00);
        `CHK(cpu_req.irq, 1'b0)
        conclude();
    end

    // Watchdog sized well above the few hundred cycles the sequence needs.
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        conclude();
    end
endmodule
